// [pkg/eqoc_params.svh]
// eqoc constants: register offsets, field positions, strap codes and timings
`ifndef EQOC_PARAMS_SVH
`define EQOC_PARAMS_SVH

`define EQOC_OFS_SWING0 8'h30
`define EQOC_OFS_DEEMP0 8'h31
`define EQOC_OFS_SWING1 8'h32
`define EQOC_OFS_DEEMP1 8'h33
`define EQOC_OFS_ROUTE 8'h40
`define EQOC_SWING_OVR_BIT 5
`define EQOC_DEEMP_OVR_BIT 6
`define EQOC_ROUTE_OVR_BIT 7
`define EQOC_ROUTE_DUAL_BIT 0
`define EQOC_ROUTE_BYP_OVR_BIT 6
`define EQOC_ROUTE_BYP_BIT 1
`define EQOC_ROUTE_SPLIT_BIT 2
`define EQOC_REG_RESET 8'h00
`define EQOC_CODE_H 3'h0
`define EQOC_CODE_F 3'h2
`define EQOC_CODE_R 3'h3
`define EQOC_CODE_L 3'h5
// strap thresholds as fractions of the io supply on an 8-bit sampled scale; equal goes up
`define EQOC_THR_LR 8'h33
`define EQOC_THR_RF 8'h80
`define EQOC_THR_FH 8'hcc
`define EQOC_ADAPT_MS 5
`define EQOC_CLK_MHZ 200

`endif

// [pkg/eqoc_pkg.sv]
// eqoc types: strap levels, carrier states and grouped output controls
package eqoc_pkg;
    typedef enum logic [1:0] {
        EQOC_LVL_L = 2'b00,
        EQOC_LVL_R = 2'b01,
        EQOC_LVL_F = 2'b10,
        EQOC_LVL_H = 2'b11
    } eqoc_level_e;

    typedef enum logic [1:0] {
        EQOC_CD_SAVE = 2'b00,
        EQOC_CD_ADAPT = 2'b01,
        EQOC_CD_LOCK = 2'b10
    } eqoc_cd_e;

    typedef struct packed {
        logic [2:0] swing;
        logic [2:0] deemp;
        logic enable;
    } eqoc_drv_s;

    typedef struct packed {
        logic eq_power;
        logic bypass;
        logic split_mode;
        logic boost_auto;
    } eqoc_path_s;
endpackage

// [core/eqoc_level_dec.sv]
// eqoc four-level strap decoder for one configuration pin
`timescale 1ns/1ps
`default_nettype none
`include "eqoc_params.svh"
module eqoc_level_dec (
    input wire logic [7:0] pin_level_i,
    input wire logic pin_open_i,
    output eqoc_pkg::eqoc_level_e level_o
);
    // threshold compare; open pin biases to F
    always_comb begin
        // [RL2] open means F
        if (pin_open_i) begin
            level_o = eqoc_pkg::EQOC_LVL_F;
        // [RL1] three thresholds
        end else if (pin_level_i < `EQOC_THR_LR) begin
            level_o = eqoc_pkg::EQOC_LVL_L;
        end else if (pin_level_i < `EQOC_THR_RF) begin
            level_o = eqoc_pkg::EQOC_LVL_R;
        end else if (pin_level_i < `EQOC_THR_FH) begin
            level_o = eqoc_pkg::EQOC_LVL_F;
        end else begin
            level_o = eqoc_pkg::EQOC_LVL_H;
        end
    end
endmodule
`default_nettype wire

// [core/eqoc_drv_sel.sv]
// eqoc per-output swing and de-emphasis selection, strap or override
`timescale 1ns/1ps
`default_nettype none
`include "eqoc_params.svh"
module eqoc_drv_sel (
    input wire logic [2:0] strap_code_i,
    input wire logic [7:0] swing_reg_i,
    input wire logic [7:0] deemp_reg_i,
    input wire logic enable_i,
    output eqoc_pkg::eqoc_drv_s drv_o
);
    // override only while its enable bit stands, full 0..7 range
    always_comb begin
        drv_o.enable = enable_i;
        // [RL11] swing override field
        // [RL15] fall back when cleared
        drv_o.swing = swing_reg_i[`EQOC_SWING_OVR_BIT] ? swing_reg_i[2:0] : strap_code_i;
        // [RL13] codes up to seven
        drv_o.deemp = deemp_reg_i[`EQOC_DEEMP_OVR_BIT] ? deemp_reg_i[2:0] : strap_code_i;
    end
endmodule
`default_nettype wire

// [core/eqoc_top.sv]
// eqoc output control: straps, carrier detect, routing and driver levels
// Notes on behaviour
// [RL1] each strap resolves to L, R, F or H at 0.2/0.5/0.8 supply
// [RL2] an unconnected strap reads as level F
// [RL3] carrier above threshold starts adaptation; indicator low after adaptation
// [RL4] no carrier: equalizer powered down, indicator high
// [RL5] power save entered without input, left when signal returns
// [RL6] equalization boost chosen automatically from signal quality
// [RL7] routing H feeds both outputs, F only the first; R, L reserved
// [RL8] routing strap is default; override bits take precedence
// [RL9] source strap H bypasses equalizer, F equalized; overrides supersede
// [RL10] drive strap sets both outputs; registers set each independently
// [RL11] override enables at 0x30/0x32 bit5 and 0x31/0x33 bit6, code 2:0
// [RL12] drive strap H=0, F=2, R=3, L=5 for swing and de-emphasis
// [RL13] code fields accept values up to seven
// [RL14] controller enables splitter mode for half-amplitude input; here split_mode is set only by route register bit 2
// [RL15] straps decoded once after reset; overrides live while enabled
`timescale 1ns/1ps
`default_nettype none
`include "eqoc_params.svh"
module eqoc_top #(
    parameter int ADAPT_CYCLES = `EQOC_ADAPT_MS * 1000 * `EQOC_CLK_MHZ
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] route_pin_i,
    input wire logic route_open_i,
    input wire logic [7:0] source_pin_i,
    input wire logic source_open_i,
    input wire logic [7:0] drive_level_strap_i,
    input wire logic drive_level_open_i,
    input wire logic carrier_above_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic carrier_indicator_n_o,
    output logic power_save_o,
    output eqoc_pkg::eqoc_path_s path_o,
    output eqoc_pkg::eqoc_drv_s first_output_o,
    output eqoc_pkg::eqoc_drv_s second_output_o
);
    // decoded strap levels, live and latched
    eqoc_pkg::eqoc_level_e route_lvl;
    eqoc_pkg::eqoc_level_e source_lvl;
    eqoc_pkg::eqoc_level_e drive_lvl;
    eqoc_pkg::eqoc_level_e route_q, route_d;
    eqoc_pkg::eqoc_level_e source_q, source_d;
    eqoc_pkg::eqoc_level_e drive_q, drive_d;
    logic latched_q, latched_d;
    // register file bytes and read path
    logic [7:0] sw0_q, sw0_d;
    logic [7:0] de0_q, de0_d;
    logic [7:0] sw1_q, sw1_d;
    logic [7:0] de1_q, de1_d;
    logic [7:0] rt_q, rt_d;
    logic [7:0] rdata_d;
    logic [7:0] status_byte;
    // carrier detect state and adaptation timer
    eqoc_pkg::eqoc_cd_e cd_q, cd_d;
    logic [31:0] cnt_q, cnt_d;
    logic adapt_done;
    // shared strap code, routing and driver selections
    logic [2:0] strap_code;
    logic dual_en;
    logic bypass_sel;
    eqoc_pkg::eqoc_drv_s drv0, drv1;
    eqoc_pkg::eqoc_drv_s first_output_d, second_output_d;
    eqoc_pkg::eqoc_path_s path_d, path_q;

    // one decoder per strap pin, all on the same thresholds
    eqoc_level_dec u_route (
        .pin_level_i(route_pin_i),
        .pin_open_i(route_open_i),
        .level_o(route_lvl)
    );
    eqoc_level_dec u_source (
        .pin_level_i(source_pin_i),
        .pin_open_i(source_open_i),
        .level_o(source_lvl)
    );
    eqoc_level_dec u_drive (
        .pin_level_i(drive_level_strap_i),
        .pin_open_i(drive_level_open_i),
        .level_o(drive_lvl)
    );

    // straps captured on the first clock after reset release, then frozen
    always_comb begin
        route_d = route_q;
        source_d = source_q;
        drive_d = drive_q;
        latched_d = 1'b1;
        // [RL15] decode once after reset
        if (!latched_q) begin
            route_d = route_lvl;
            source_d = source_lvl;
            drive_d = drive_lvl;
        end
    end

    // latched strap levels and the one-shot capture flag
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            route_q <= eqoc_pkg::EQOC_LVL_F;
            source_q <= eqoc_pkg::EQOC_LVL_F;
            drive_q <= eqoc_pkg::EQOC_LVL_F;
            latched_q <= 1'b0;
        end else begin
            route_q <= route_d;
            source_q <= source_d;
            drive_q <= drive_d;
            latched_q <= latched_d;
        end
    end

    // register file: writes store, reads show the stored byte except at the route offset
    always_comb begin
        sw0_d = sw0_q;
        de0_d = de0_q;
        sw1_d = sw1_q;
        de1_d = de1_q;
        rt_d = rt_q;
        if (reg_wr_i) begin
            // unmapped offsets fall to the default and are dropped
            unique case (reg_addr_i)
                `EQOC_OFS_SWING0: sw0_d = reg_wdata_i;
                `EQOC_OFS_DEEMP0: de0_d = reg_wdata_i;
                `EQOC_OFS_SWING1: sw1_d = reg_wdata_i;
                `EQOC_OFS_DEEMP1: de1_d = reg_wdata_i;
                `EQOC_OFS_ROUTE: rt_d = reg_wdata_i;
                default: ;
            endcase
        end
    end

    // route register read-back: control bits plus carrier and power state; bit 3 reads zero
    always_comb begin
        status_byte = {rt_q[7:6], ~carrier_indicator_n_o, power_save_o, 1'b0, rt_q[2:0]};
    end

    // read mux; unmapped offsets read zero so probing is harmless
    always_comb begin
        unique case (reg_addr_i)
            `EQOC_OFS_SWING0: rdata_d = sw0_q;
            `EQOC_OFS_DEEMP0: rdata_d = de0_q;
            `EQOC_OFS_SWING1: rdata_d = sw1_q;
            `EQOC_OFS_DEEMP1: rdata_d = de1_q;
            `EQOC_OFS_ROUTE: rdata_d = status_byte;
            default: rdata_d = 8'h00;
        endcase
    end

    // register file bytes
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sw0_q <= `EQOC_REG_RESET;
            de0_q <= `EQOC_REG_RESET;
            sw1_q <= `EQOC_REG_RESET;
            de1_q <= `EQOC_REG_RESET;
            rt_q <= `EQOC_REG_RESET;
        end else begin
            sw0_q <= sw0_d;
            de0_q <= de0_d;
            sw1_q <= sw1_d;
            de1_q <= de1_d;
            rt_q <= rt_d;
        end
    end

    // read data one cycle after the address, from a flop
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_d;
        end
    end

    // adaptation ends after the full timer; 32 bits cover any sane clock rate
    assign adapt_done = (cnt_q >= 32'(ADAPT_CYCLES - 1));

    // carrier detect: save -> adapt -> lock; any carrier loss returns to save
    always_comb begin
        cd_d = cd_q;
        cnt_d = cnt_q;
        unique case (cd_q)
            eqoc_pkg::EQOC_CD_SAVE: begin
                cnt_d = 32'h0;
                // [RL5] leave power save
                if (carrier_above_i) begin
                    cd_d = eqoc_pkg::EQOC_CD_ADAPT;
                end
            end
            eqoc_pkg::EQOC_CD_ADAPT: begin
                // [RL3] adapt before indicating
                if (!carrier_above_i) begin
                    cd_d = eqoc_pkg::EQOC_CD_SAVE;
                end else if (adapt_done) begin
                    cd_d = eqoc_pkg::EQOC_CD_LOCK;
                end else begin
                    cnt_d = cnt_q + 32'h1;
                end
            end
            eqoc_pkg::EQOC_CD_LOCK: begin
                // [RL4] loss powers down
                if (!carrier_above_i) begin
                    cd_d = eqoc_pkg::EQOC_CD_SAVE;
                end
            end
            default: cd_d = eqoc_pkg::EQOC_CD_SAVE;
        endcase
    end

    // carrier state and adaptation timer
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cd_q <= eqoc_pkg::EQOC_CD_SAVE;
            cnt_q <= 32'h0;
        end else begin
            cd_q <= cd_d;
            cnt_q <= cnt_d;
        end
    end

    // [RL3] indicator low only once locked
    assign carrier_indicator_n_o = (cd_q != eqoc_pkg::EQOC_CD_LOCK);
    // [RL5] power save without input
    assign power_save_o = (cd_q == eqoc_pkg::EQOC_CD_SAVE);

    // drive strap code shared by both outputs
    always_comb begin
        // [RL12] strap to code map
        unique case (drive_q)
            eqoc_pkg::EQOC_LVL_H: strap_code = `EQOC_CODE_H;
            eqoc_pkg::EQOC_LVL_F: strap_code = `EQOC_CODE_F;
            eqoc_pkg::EQOC_LVL_R: strap_code = `EQOC_CODE_R;
            eqoc_pkg::EQOC_LVL_L: strap_code = `EQOC_CODE_L;
        endcase
    end

    // routing and source: strap by default, register when its override is set;
    // reserved strap levels fall back to the single-output, equalized defaults
    always_comb begin
        // [RL8] override beats strap
        if (rt_q[`EQOC_ROUTE_OVR_BIT]) begin
            dual_en = rt_q[`EQOC_ROUTE_DUAL_BIT];
        end else begin
            // [RL7] H both, F first only
            dual_en = (route_q == eqoc_pkg::EQOC_LVL_H);
        end
    end

    // source select and path controls
    always_comb begin
        // [RL9] bypass select
        if (rt_q[`EQOC_ROUTE_BYP_OVR_BIT]) begin
            bypass_sel = rt_q[`EQOC_ROUTE_BYP_BIT];
        end else begin
            bypass_sel = (source_q == eqoc_pkg::EQOC_LVL_H);
        end
        // [RL4] equalizer off in save
        path_d.eq_power = (cd_q != eqoc_pkg::EQOC_CD_SAVE);
        path_d.bypass = bypass_sel;
        // [RL14] splitter mode by register
        path_d.split_mode = rt_q[`EQOC_ROUTE_SPLIT_BIT];
        // [RL6] boost loop always automatic
        path_d.boost_auto = 1'b1;
    end

    // [RL10] per-output drive selection
    eqoc_drv_sel u_drv0 (
        .strap_code_i(strap_code),
        .swing_reg_i(sw0_q),
        .deemp_reg_i(de0_q),
        .enable_i(1'b1),
        .drv_o(drv0)
    );
    // second output carries the routing enable
    eqoc_drv_sel u_drv1 (
        .strap_code_i(strap_code),
        .swing_reg_i(sw1_q),
        .deemp_reg_i(de1_q),
        .enable_i(dual_en),
        .drv_o(drv1)
    );

    // next driver controls, both outputs on the same registered timing
    always_comb begin
        first_output_d = drv0;
        second_output_d = drv1;
    end

    // registered data outputs keep glitches off the driver controls
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            path_q <= '0;
            first_output_o <= '0;
            second_output_o <= '0;
        end else begin
            path_q <= path_d;
            first_output_o <= first_output_d;
            second_output_o <= second_output_d;
        end
    end
    assign path_o = path_q;
endmodule
`default_nettype wire

// [tb/eqoc_assertions.sv]
// eqoc checker: carrier sequencing, overrides and read-back at the top ports
`timescale 1ns/1ps
`default_nettype none
`include "eqoc_params.svh"
module eqoc_assertions #(
    parameter int ADAPT_CYCLES = 20
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] drive_level_strap_i,
    input wire logic drive_level_open_i,
    input wire logic carrier_above_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic carrier_indicator_n_o,
    input wire logic power_save_o,
    input wire eqoc_pkg::eqoc_drv_s first_output_o,
    input wire eqoc_pkg::eqoc_drv_s second_output_o
);
    logic [7:0] run_q;
    logic [7:0] run_d;
    logic [2:0] strap_code;
    // carrier run length; saturates so a long lock never wraps below the bound
    always_comb begin
        run_d = 8'h00;
        if (carrier_above_i) begin
            run_d = (run_q == 8'hff) ? run_q : run_q + 8'h01;
        end
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_q <= 8'h00;
        end else begin
            run_q <= run_d;
        end
    end
    // expected drive code; only valid while the strap is held since reset
    assign strap_code = drive_level_open_i ? `EQOC_CODE_F
        : (drive_level_strap_i >= `EQOC_THR_FH) ? `EQOC_CODE_H
        : (drive_level_strap_i >= `EQOC_THR_RF) ? `EQOC_CODE_F
        : (drive_level_strap_i >= `EQOC_THR_LR) ? `EQOC_CODE_R : `EQOC_CODE_L;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wr(logic [7:0] ofs);
        reg_wr_i && reg_addr_i == ofs;
    endsequence
    // lock shows in the same cycle that the run reaches the adaptation length plus one
    chk_lock_after_adapt: assert property (
        !carrier_indicator_n_o |-> int'(run_q) >= ADAPT_CYCLES + 1)
        else $error("carrier indicator low before adaptation");
    chk_lock_in_time: assert property (
        int'(run_q) == ADAPT_CYCLES + 1 |-> !carrier_indicator_n_o)
        else $error("carrier indicator not low after adaptation");
    chk_drop_to_save: assert property (
        !carrier_above_i |=> carrier_indicator_n_o && power_save_o)
        else $error("no power save after carrier loss");
    chk_save_exit: assert property (
        carrier_above_i |=> !power_save_o)
        else $error("power save kept with carrier present");
    chk_save_ind_high: assert property (
        power_save_o |-> carrier_indicator_n_o)
        else $error("indicator low in power save");
    chk_swing0_ovr: assert property (
        s_wr(`EQOC_OFS_SWING0) ##0 reg_wdata_i[`EQOC_SWING_OVR_BIT]
        |-> ##2 first_output_o.swing == $past(reg_wdata_i[2:0], 2))
        else $error("first swing override not applied");
    chk_swing0_strap: assert property (
        s_wr(`EQOC_OFS_SWING0) ##0 !reg_wdata_i[`EQOC_SWING_OVR_BIT]
        |-> ##2 first_output_o.swing == strap_code)
        else $error("first swing not back to strap value");
    chk_deemp1_ovr: assert property (
        s_wr(`EQOC_OFS_DEEMP1) ##0 reg_wdata_i[`EQOC_DEEMP_OVR_BIT]
        |-> ##2 second_output_o.deemp == $past(reg_wdata_i[2:0], 2))
        else $error("second de-emphasis override not applied");
    chk_unmapped_zero: assert property (
        !(reg_addr_i inside {[8'h30:8'h33], 8'h40}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind eqoc_top eqoc_assertions #(.ADAPT_CYCLES(ADAPT_CYCLES)) chk_u (.mclk_i, .rstn_i,
    .drive_level_strap_i, .drive_level_open_i, .carrier_above_i, .reg_wr_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .carrier_indicator_n_o, .power_save_o, .first_output_o,
    .second_output_o);
`default_nettype wire

// [tb/eqoc_sink_model.sv]
// eqoc downstream receiver model: counts driver lanes it sees enabled
`timescale 1ns/1ps
`default_nettype none
module eqoc_sink_model (
    input wire logic mclk_i,
    input wire eqoc_pkg::eqoc_drv_s first_output_i,
    input wire eqoc_pkg::eqoc_drv_s second_output_i,
    output logic [1:0] lanes_o
);
    // a disabled driver carries nothing, so it adds no lane
    always_ff @(posedge mclk_i) begin
        lanes_o <= {1'b0, first_output_i.enable} + {1'b0, second_output_i.enable};
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// eqoc testbench: strap decode, register overrides and carrier sequencing
`timescale 1ns/1ps
`default_nettype none
`include "eqoc_params.svh"
module testbench;
    localparam int ADAPT_CYCLES = 20;
    logic mclk_i = 1'b0, rstn_i = 1'b0, carrier_above_i = 1'b0, reg_wr_i = 1'b0;
    logic route_open_i = 1'b0, source_open_i = 1'b0, drive_level_open_i = 1'b0;
    logic [7:0] route_pin_i = 8'h00, source_pin_i = 8'h00, drive_level_strap_i = 8'h00;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d;
    logic carrier_indicator_n_o, power_save_o;
    logic [1:0] lanes;
    eqoc_pkg::eqoc_path_s path_o;
    eqoc_pkg::eqoc_drv_s first_output_o, second_output_o;
    int failures = 0;
    int check_count = 0;
    // 200 MHz clock
    always #2.5 mclk_i = ~mclk_i;
    eqoc_top #(.ADAPT_CYCLES(ADAPT_CYCLES)) dut_u (.mclk_i, .rstn_i, .route_pin_i,
        .route_open_i, .source_pin_i, .source_open_i, .drive_level_strap_i,
        .drive_level_open_i, .carrier_above_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
        .reg_rdata_o, .carrier_indicator_n_o, .power_save_o, .path_o, .first_output_o,
        .second_output_o);
    eqoc_sink_model sink_u (.mclk_i, .first_output_i(first_output_o),
        .second_output_i(second_output_o), .lanes_o(lanes));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // straps are only sampled after reset, so each level needs a fresh reset
    task automatic restart(input logic [7:0] v, input logic open);
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        {route_pin_i, source_pin_i, drive_level_strap_i} <= {3{v}};
        {route_open_i, source_open_i, drive_level_open_i} <= {3{open}};
        cycles(5);
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        cycles(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        reg_addr_i <= a;
        cycles(2);
        d = reg_rdata_o;
    endtask
    task automatic test_straps();
        logic [7:0] volt [8] = '{8'h00, 8'h32, 8'h33, 8'h7f, 8'h80, 8'hcb, 8'hcc, 8'hff};
        logic [2:0] code [8] = '{`EQOC_CODE_L, `EQOC_CODE_L, `EQOC_CODE_R, `EQOC_CODE_R,
            `EQOC_CODE_F, `EQOC_CODE_F, `EQOC_CODE_H, `EQOC_CODE_H};
        for (int i = 0; i < 8; i++) begin
            restart(volt[i], 1'b0);
            check("swing0", {5'h00, first_output_o.swing}, {5'h00, code[i]}); // level edge
            check("deemp1", {5'h00, second_output_o.deemp}, {5'h00, code[i]}); // joint
            check("second_output_en", {7'h00, second_output_o.enable}, {7'h00, i > 5}); // routing
            check("bypass", {7'h00, path_o.bypass}, {7'h00, i > 5}); // source
            check("lanes", {6'h00, lanes}, (i > 5) ? 8'h02 : 8'h01); // receiver
        end
        restart(8'h00, 1'b1);
        check("open", {5'h00, first_output_o.swing}, {5'h00, `EQOC_CODE_F}); // open pin
        $display("test_straps done");
    endtask
    task automatic test_override();
        restart(8'h99, 1'b0);
        wr(`EQOC_OFS_SWING0, 8'h27);
        wr(`EQOC_OFS_DEEMP1, 8'h45);
        cycles(2);
        check("swing0", {5'h00, first_output_o.swing}, 8'h07); // top code
        check("deemp1", {5'h00, second_output_o.deemp}, 8'h05); // override
        check("swing1", {5'h00, second_output_o.swing}, 8'h02); // per output
        rd(`EQOC_OFS_SWING0);
        check("rd30", d, 8'h27); // read back
        rd(8'h50);
        check("rd50", d, 8'h00); // unmapped
        wr(`EQOC_OFS_SWING0, 8'h07);
        cycles(2);
        check("swing0_off", {5'h00, first_output_o.swing}, 8'h02); // fall back
        wr(`EQOC_OFS_ROUTE, 8'hc7);
        cycles(3);
        check("second_output_ovr", {7'h00, second_output_o.enable}, 8'h01); // precedence
        check("byp_ovr", {7'h00, path_o.bypass}, 8'h01); // supersede
        check("split", {7'h00, path_o.split_mode}, 8'h01); // splitter mode
        check("lanes", {6'h00, lanes}, 8'h02); // receiver
        rd(`EQOC_OFS_ROUTE);
        check("rd40", d, 8'hd7); // status read, power save
        $display("test_override done");
    endtask
    task automatic test_carrier();
        int n;
        restart(8'hff, 1'b0);
        for (int k = 0; k < 2; k++) begin
            check("save", {7'h00, power_save_o}, 8'h01); // idle save
            @(posedge mclk_i);
            carrier_above_i <= 1'b1;
            cycles(2);
            check("save_exit", {7'h00, power_save_o}, 8'h00); // exit
            n = 0;
            while (carrier_indicator_n_o !== 1'b0 && n < 100) begin
                cycles(1);
                n++;
            end
            if (n == 100) begin // timeout
                failures++;
                results();
            end
            check("adapt", 8'(n), 8'(ADAPT_CYCLES - 1)); // adapt time
            check("boost", {7'h00, path_o.boost_auto}, 8'h01); // auto boost
            check("eq_on", {7'h00, path_o.eq_power}, 8'h01); // powered
            @(posedge mclk_i);
            carrier_above_i <= 1'b0;
            cycles(3);
            check("ind_off", {7'h00, carrier_indicator_n_o}, 8'h01); // no input
            check("eq_off", {7'h00, path_o.eq_power}, 8'h00); // powered down
        end
        $display("test_carrier done");
    endtask
    initial begin
        test_straps();
        test_override();
        test_carrier();
        results();
    end
endmodule
`default_nettype wire
